// file: verilog/sqs_params.svh
`ifndef SQS_PARAMS_SVH
`define SQS_PARAMS_SVH

// Core clock period in ns
`define SQS_CLK_PERIOD_NS 4
// Coil-drive oscillator period in ns (20 kHz)
`define SQS_OSC_PERIOD_NS 50000
// Cycles of the core clock per oscillator period
`define SQS_OSC_CYCLES (`SQS_OSC_PERIOD_NS / `SQS_CLK_PERIOD_NS)
// Width of the oscillator divider counter
`define SQS_DIV_W 16
// Width of the quarter-step position counter
`define SQS_POS_W 4
// Position after reset
`define SQS_POS_RESET 4'h0
// Idle level of the active-low step pin
`define SQS_STEP_IDLE 1'b1
// Level of the direction pin assumed during reset
`define SQS_DIR_RESET 1'b0
// Direction pin level meaning counter-clockwise
`define SQS_DIR_CCW 1'b1

`endif

// file: verilog/sqs_pkg.sv
`include "sqs_params.svh"

package sqs_pkg;

	typedef enum logic [1:0] {
		SQS_OFF,
		SQS_RED,
		SQS_FULL
	} sqs_level_e;

	typedef struct packed {
		logic a_pos;
		logic a_neg;
		logic b_pos;
		logic b_neg;
		logic a_pos_red;
		logic a_neg_red;
		logic b_pos_red;
		logic b_neg_red;
	} sqs_drive_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} sqs_sync_s;

	typedef struct packed {
		logic [`SQS_POS_W-1:0] pos;
		logic step_prev;
		logic [`SQS_DIV_W-1:0] div;
		logic tick;
		logic moved;
		sqs_drive_s drive;
	} sqs_state_s;

endpackage : sqs_pkg

// file: verilog/sqs_sync.sv
`timescale 1ns/100ps

module sqs_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	import sqs_pkg::*;

	sqs_sync_s st_r;
	sqs_sync_s st_nxt;

	// Three stages; output follows once stages two and three agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= {4{RESET_VAL}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.q;

endmodule : sqs_sync

// file: verilog/sqs_top.sv
`timescale 1ns/100ps
`include "sqs_params.svh"

// Overview of operation
// - Each step pulse moves the counter by one; direction selects up or down.
// - Sixteen quarter-steps of 0.45 deg make four 1.8 deg steps per 7.2 deg.
// - Opposite direction walks the same coil pattern in reverse order.
// - Counter value is translated by a fixed table into four coil drives.
// - Direction high steps counter-clockwise, low steps clockwise.
// - Some states drive reduced 41 percent current, flagged per polarity.
// - Coil-drive outputs are timed by a 20 kHz, 50 us oscillator tick.

module sqs_top #(
	parameter int unsigned OSC_CYCLES = `SQS_OSC_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic CARRIAGE_STEP_PULSE_N,
	input wire logic CARRIAGE_DIRECTION,
	output logic WINDING_A_POS_DRIVE,
	output logic WINDING_A_NEG_DRIVE,
	output logic WINDING_B_POS_DRIVE,
	output logic WINDING_B_NEG_DRIVE,
	output logic WINDING_A_POS_REDUCED,
	output logic WINDING_A_NEG_REDUCED,
	output logic WINDING_B_POS_REDUCED,
	output logic WINDING_B_NEG_REDUCED,
	output logic [`SQS_POS_W-1:0] POSITION,
	output logic DRIVE_TICK,
	output logic STEP_TAKEN
);
	import sqs_pkg::*;

	localparam logic [`SQS_DIV_W-1:0] DIV_LAST =
		`SQS_DIV_W'(OSC_CYCLES - 1);

	// Ends of the sixteen-state quarter-step cycle
	localparam logic [`SQS_POS_W-1:0] POS_FIRST = '0;
	localparam logic [`SQS_POS_W-1:0] POS_LAST = '1;
	localparam logic [`SQS_POS_W-1:0] POS_ONE = `SQS_POS_W'(1);

	// Filtered pins and state
	logic step_n_f;
	logic dir_f;
	sqs_state_s st_r;
	sqs_state_s st_nxt;
	sqs_drive_s table_out;

	// Pin filters for the step and direction inputs
	sqs_sync #(
		.RESET_VAL(`SQS_STEP_IDLE)
	) u_step_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.din(CARRIAGE_STEP_PULSE_N),
		.dout(step_n_f)
	);

	sqs_sync #(
		.RESET_VAL(`SQS_DIR_RESET)
	) u_dir_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.din(CARRIAGE_DIRECTION),
		.dout(dir_f)
	);

	// Place one winding level onto a polarity pair
	function automatic void put_level(
		input sqs_level_e lvl,
		input logic neg,
		output logic pos_drv,
		output logic neg_drv,
		output logic pos_red,
		output logic neg_red
	);
		logic on;
		logic red;
		on = (lvl != SQS_OFF);
		red = (lvl == SQS_RED);
		pos_drv = on & ~neg;
		neg_drv = on & neg;
		pos_red = red & ~neg;
		neg_red = red & neg;
	endfunction : put_level

	// Quarter-step table: four magnitude steps per quadrant, quadrants
	// rotate the windings by one full step each
	function automatic sqs_drive_s lookup(
		input logic [`SQS_POS_W-1:0] pos
	);
		sqs_drive_s d;
		sqs_level_e m1;
		sqs_level_e m2;
		sqs_level_e la;
		sqs_level_e lb;
		logic na;
		logic nb;
		d = '0;
		case (pos[1:0])
			2'h0: begin
				m1 = SQS_FULL;
				m2 = SQS_OFF;
			end
			2'h1: begin
				m1 = SQS_FULL;
				m2 = SQS_RED;
			end
			2'h2: begin
				m1 = SQS_FULL;
				m2 = SQS_FULL;
			end
			default: begin
				m1 = SQS_RED;
				m2 = SQS_FULL;
			end
		endcase
		case (pos[3:2])
			2'h0: begin
				la = m1;
				na = 1'b0;
				lb = m2;
				nb = 1'b0;
			end
			2'h1: begin
				la = m2;
				na = 1'b1;
				lb = m1;
				nb = 1'b0;
			end
			2'h2: begin
				la = m1;
				na = 1'b1;
				lb = m2;
				nb = 1'b1;
			end
			default: begin
				la = m2;
				na = 1'b0;
				lb = m1;
				nb = 1'b1;
			end
		endcase
		put_level(la, na, d.a_pos, d.a_neg, d.a_pos_red, d.a_neg_red);
		put_level(lb, nb, d.b_pos, d.b_neg, d.b_pos_red, d.b_neg_red);
		return d;
	endfunction : lookup

	// Fixed translation of the current position
	assign table_out = lookup(st_r.pos);

	always_comb begin
		st_nxt = st_r;
		// Step edge detection and position counter
		st_nxt.step_prev = step_n_f;
		st_nxt.moved = 1'b0;
		// Falling edge of the filtered active-low step pulse
		if (st_r.step_prev && !step_n_f) begin
			st_nxt.moved = 1'b1;
			if (dir_f == `SQS_DIR_CCW) begin
				// Counter-clockwise walks the pattern backwards
				if (st_r.pos == POS_FIRST) begin
					st_nxt.pos = POS_LAST;
				end else begin
					st_nxt.pos = st_r.pos - POS_ONE;
				end
			end else begin
				// Clockwise walks the sixteen states forwards
				if (st_r.pos == POS_LAST) begin
					st_nxt.pos = POS_FIRST;
				end else begin
					st_nxt.pos = st_r.pos + POS_ONE;
				end
			end
		end

		// Oscillator divider for the coil-drive stage
		st_nxt.tick = 1'b0;
		if (st_r.div == DIV_LAST) begin
			st_nxt.div = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.div = st_r.div + `SQS_DIV_W'(1);
		end

		// Coil drives change only on the oscillator tick
		if (st_r.tick) begin
			st_nxt.drive = table_out;
		end
	end

	// Asynchronous reset: position home, drives off
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			st_r.pos <= `SQS_POS_RESET;
			st_r.step_prev <= `SQS_STEP_IDLE;
			st_r.div <= '0;
			st_r.tick <= 1'b0;
			st_r.moved <= 1'b0;
			st_r.drive <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign WINDING_A_POS_DRIVE = st_r.drive.a_pos;
	assign WINDING_A_NEG_DRIVE = st_r.drive.a_neg;
	assign WINDING_B_POS_DRIVE = st_r.drive.b_pos;
	assign WINDING_B_NEG_DRIVE = st_r.drive.b_neg;
	assign WINDING_A_POS_REDUCED = st_r.drive.a_pos_red;
	assign WINDING_A_NEG_REDUCED = st_r.drive.a_neg_red;
	assign WINDING_B_POS_REDUCED = st_r.drive.b_pos_red;
	assign WINDING_B_NEG_REDUCED = st_r.drive.b_neg_red;
	assign POSITION = st_r.pos;
	assign DRIVE_TICK = st_r.tick;
	assign STEP_TAKEN = st_r.moved;

endmodule : sqs_top

// file: dv/sqs_top_monitor.sv
`timescale 1ns/100ps
module sqs_top_monitor #(
	parameter int OSC_CYCLES = 8
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic CARRIAGE_STEP_PULSE_N,
	input wire logic CARRIAGE_DIRECTION,
	input wire logic WINDING_A_POS_DRIVE,
	input wire logic WINDING_A_NEG_DRIVE,
	input wire logic WINDING_B_POS_DRIVE,
	input wire logic WINDING_B_NEG_DRIVE,
	input wire logic WINDING_A_POS_REDUCED,
	input wire logic [3:0] POSITION,
	input wire logic DRIVE_TICK,
	input wire logic STEP_TAKEN
);
	localparam int TK = OSC_CYCLES - 1;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	chk_step_once: assert property (STEP_TAKEN |=> !STEP_TAKEN)
		else $error("step pulse too long");
	chk_step_delay: assert property ($fell(CARRIAGE_STEP_PULSE_N) |->
		##5 STEP_TAKEN) else $error("step not taken");
	chk_pos_hold: assert property (!STEP_TAKEN |-> $stable(POSITION))
		else $error("position moved");
	chk_count_up: assert property (STEP_TAKEN && !CARRIAGE_DIRECTION |->
		POSITION == $past(POSITION) + 4'h1) else $error("bad up");
	chk_count_down: assert property (STEP_TAKEN && CARRIAGE_DIRECTION |->
		POSITION == $past(POSITION) - 4'h1) else $error("bad down");
	chk_tick_period: assert property (DRIVE_TICK |=> !DRIVE_TICK
		##TK DRIVE_TICK) else $error("bad tick");
	chk_drive_hold: assert property (!$past(DRIVE_TICK) |->
		$stable({WINDING_A_POS_DRIVE, WINDING_A_NEG_DRIVE,
		WINDING_B_POS_DRIVE, WINDING_B_NEG_DRIVE})) else $error("drive moved");
	chk_drive_pol: assert property (!(WINDING_A_POS_DRIVE &&
		WINDING_A_NEG_DRIVE) && !(WINDING_B_POS_DRIVE && WINDING_B_NEG_DRIVE)
		&& (!WINDING_A_POS_REDUCED || WINDING_A_POS_DRIVE))
		else $error("bad drive");
endmodule : sqs_top_monitor
bind sqs_top sqs_top_monitor #(.OSC_CYCLES(OSC_CYCLES)) mon (.*);

// file: dv/sqs_step_src.sv
`timescale 1ns/100ps
module sqs_step_src (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic dir_in,
	input wire logic [3:0] gap,
	output logic step_n,
	output logic dir,
	output logic busy
);
	logic [5:0] cnt_r;
	assign busy = cnt_r != 6'h00;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 6'h00;
			step_n <= 1'b1;
			dir <= 1'b0;
		end else if (!busy && go) begin
			// Direction settles seven cycles before the fall
			dir <= dir_in;
			cnt_r <= 6'h06 + {1'b0, gap, 1'b0};
		end else if (busy) begin
			cnt_r <= cnt_r - 6'h01;
			// One pulse per request, low and high gap cycles each
			step_n <= !(cnt_r <= {gap, 1'b0} && cnt_r > {2'h0, gap});
		end
	end
endmodule : sqs_step_src

// file: dv/sqs_top_tb.sv
`timescale 1ns/100ps
module sqs_top_tb;
	import sqs_pkg::*;
	logic CORE_CLK = 1'b0, RESET = 1'b1, go = 1'b0, d = 1'b0, busy, tk;
	logic CARRIAGE_STEP_PULSE_N, CARRIAGE_DIRECTION, DRIVE_TICK, STEP_TAKEN;
	logic WINDING_A_POS_DRIVE, WINDING_A_NEG_DRIVE, WINDING_B_POS_DRIVE;
	logic WINDING_B_NEG_DRIVE, WINDING_A_POS_REDUCED, WINDING_A_NEG_REDUCED;
	logic WINDING_B_POS_REDUCED, WINDING_B_NEG_REDUCED;
	logic [3:0] POSITION, g = 4'h3, e = 4'h0, tp;
	logic [3:0] q [$];
	logic [7:0] tbl [16] = '{8'h80, 8'hA2, 8'hA0, 8'hA8, 8'h20, 8'h64,
		8'h60, 8'h62, 8'h40, 8'h51, 8'h50, 8'h54, 8'h10, 8'h98, 8'h90, 8'h91};
	int bad_count = 0, check_count = 0;
	always #2 CORE_CLK = ~CORE_CLK;
	sqs_top #(.OSC_CYCLES(8)) dut (.*);
	sqs_step_src src (.clk(CORE_CLK), .rst(RESET), .go(go), .dir_in(d),
		.gap(g), .step_n(CARRIAGE_STEP_PULSE_N), .dir(CARRIAGE_DIRECTION),
		.busy(busy));
	task check(input logic [7:0] s, input logic [7:0] x);
		check_count++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, s, x);
		end
	endtask : check
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task step(input logic dd, input logic [3:0] gg);
		int n;
		@(posedge CORE_CLK);
		go <= 1'b1;
		d <= dd;
		g <= gg;
		e = dd ? e - 4'h1 : e + 4'h1;
		q.push_back(e);
		@(posedge CORE_CLK);
		go <= 1'b0;
		@(posedge CORE_CLK);
		n = 0;
		while (busy !== 1'b0 && n < 99) begin
			@(posedge CORE_CLK);
			n++;
		end
	endtask : step
	always @(posedge CORE_CLK) begin
		if (RESET !== 1'b0) begin
			tk = 1'b0;
		end else begin
			if (tk === 1'b1)
				check({WINDING_A_POS_DRIVE, WINDING_A_NEG_DRIVE,
					WINDING_B_POS_DRIVE, WINDING_B_NEG_DRIVE,
					WINDING_A_POS_REDUCED, WINDING_A_NEG_REDUCED,
					WINDING_B_POS_REDUCED, WINDING_B_NEG_REDUCED},
					tbl[tp]);
			if (STEP_TAKEN === 1'b1)
				check({4'h0, POSITION}, {4'h0, q.pop_front()});
			tk = DRIVE_TICK;
			tp = POSITION;
		end
	end
	initial begin
		#100000;
		bad_count++;
		end_sim;
	end
	initial begin
		void'($urandom(32'h6ae9));
		repeat (8) @(posedge CORE_CLK);
		RESET <= 1'b0;
		repeat (6) @(posedge CORE_CLK);
		repeat (17) step(1'b0, 4'h3);
		$display("count up done");
		repeat (18) step(1'b1, 4'h3);
		$display("count down done");
		repeat (30) step(1'($urandom), 4'(3 + $urandom % 4));
		$display("random steps done");
		RESET <= 1'b1;
		@(posedge CORE_CLK);
		check({4'h0, POSITION}, 8'h00);
		@(posedge CORE_CLK);
		e = 4'h0;
		RESET <= 1'b0;
		repeat (6) @(posedge CORE_CLK);
		repeat (3) step(1'b1, 4'h3);
		$display("reset wrap done");
		repeat (20) @(posedge CORE_CLK);
		check(8'(q.size()), 8'h00);
		end_sim;
	end
endmodule : sqs_top_tb
